// File: include/supervisor_pkg.sv
// Constants and types shared by the reset supervisor and its hold timer.
// Assumes a single 100 MHz system clock; every time below becomes a cycle count.
package supervisor_pkg;

    localparam longint CLK_HZ = 100_000_000;

    // Least time reset stays asserted after the last cause clears
    localparam longint HOLD_TIME_MS = 140;
    // Nominal watchdog expiry, 1.6 s written in milliseconds
    localparam longint WD_PERIOD_MS = 1600;
    // Manual reset filter window, well below the 1 us guaranteed low pulse
    localparam longint DEBOUNCE_NS = 500;

    // Least time rounds up, nominal and filter times round down
    localparam longint HOLD_CYCLES_CALC = (HOLD_TIME_MS * CLK_HZ + 999) / 1000;
    localparam longint WD_CYCLES_CALC = (WD_PERIOD_MS * CLK_HZ) / 1000;
    localparam longint DEBOUNCE_CYCLES_RAW = (DEBOUNCE_NS * CLK_HZ) / 1_000_000_000;
    localparam longint DEBOUNCE_CYCLES_CALC = (DEBOUNCE_CYCLES_RAW < 1) ? 1 : DEBOUNCE_CYCLES_RAW;

    localparam int HOLD_W = 24;
    localparam int WD_W = 28;
    localparam int DEB_W = 8;

    typedef logic [HOLD_W-1:0] hold_cnt_t;
    typedef logic [WD_W-1:0] wd_cnt_t;
    typedef logic [DEB_W-1:0] deb_cnt_t;

    localparam hold_cnt_t HOLD_CNT_ZERO = 24'h00_0000;
    localparam hold_cnt_t HOLD_CNT_ONE = 24'h00_0001;
    localparam wd_cnt_t WD_CNT_ZERO = 28'h000_0000;
    localparam wd_cnt_t WD_CNT_ONE = 28'h000_0001;
    localparam deb_cnt_t DEB_CNT_ZERO = 8'h00;
    localparam deb_cnt_t DEB_CNT_ONE = 8'h01;

    // Build-time form of the reset outputs
    typedef enum {
        OUT_PP_LOW,
        OUT_PP_HIGH,
        OUT_OD_LOW,
        OUT_PP_BOTH
    } out_mode_t;

endpackage

// File: include/hold_timer_if.sv
// Carrier between the supervisor core and its reset hold timer.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface hold_timer_if;
    logic cause;
    logic supply_low_raw;
    logic active;

    modport timer (
        input cause,
        input supply_low_raw,
        output active
    );

    modport owner (
        output cause,
        output supply_low_raw,
        input active
    );
endinterface

// File: hw/reset_hold_timer.sv
// Reset hold timer: keeps reset active while any cause is present and
// for a fixed number of cycles after the last one clears.
// Assumes the raw supply-low level may arrive at any time.
`timescale 1ns/1ps
module reset_hold_timer #(
    parameter int unsigned HOLD_CYCLES = 32'(supervisor_pkg::HOLD_CYCLES_CALC)
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    hold_timer_if.timer hold
);

    typedef struct packed {
        logic active;
        supervisor_pkg::hold_cnt_t count;
    } hold_state_t;

    localparam hold_state_t ST_ASSERT = '{active: 1'b1, count: supervisor_pkg::HOLD_CNT_ZERO};
    localparam supervisor_pkg::hold_cnt_t LAST = supervisor_pkg::hold_cnt_t'(HOLD_CYCLES - 1);

    hold_state_t st;
    hold_state_t next_st;

    always_comb begin
        next_st = st;
        if (hold.cause) begin
            // Any cause restarts the hold from zero
            next_st = ST_ASSERT;
        end else if (st.active) begin
            if (st.count >= LAST) begin
                next_st.active = 1'b0;
            end else begin
                next_st.count = st.count + supervisor_pkg::HOLD_CNT_ONE;
            end
        end
    end

    // Supply low sets the timer at once, without waiting for a clock
    always_ff @(posedge clk_sys_in or posedge hold.supply_low_raw) begin
        if (hold.supply_low_raw) begin
            st <= ST_ASSERT;
        end else if (rst_in) begin
            st <= ST_ASSERT;
        end else begin
            st <= next_st;
        end
    end

    assign hold.active = st.active;

endmodule // reset_hold_timer

// File: hw/supervisor_reset_watchdog.sv
// Processor supervisor: supply-low, manual reset and watchdog causes
// drive a held reset toward a host processor.
// Assumes manual reset and watchdog toggle inputs are synchronous to
// clk_sys_in; supply_low_in may be fully asynchronous.
`timescale 1ns/1ps

// Contract
// - Supply low asserts reset, held afterwards
// - Hold reset at least 140 ms
// - Watchdog expires 1.6 s after last clear
// - Debounce the manual reset input internally
// - Toggle pulses of 50 ns are detected
// - Output form chosen at build time
// - Watchdog and manual reset individually optional
// - Stuck toggle input triggers held reset
// - Counter clears on reset, manual, edge
// - Counter held while reset, counts after
// - Manual low forces reset, then hold
module supervisor_reset_watchdog #(
    parameter int unsigned HOLD_CYCLES = 32'(supervisor_pkg::HOLD_CYCLES_CALC),
    parameter int unsigned WD_CYCLES = 32'(supervisor_pkg::WD_CYCLES_CALC),
    parameter int unsigned DEBOUNCE_CYCLES = 32'(supervisor_pkg::DEBOUNCE_CYCLES_CALC),
    parameter supervisor_pkg::out_mode_t OUT_MODE = supervisor_pkg::OUT_PP_LOW,
    parameter bit WATCHDOG_PRESENT = 1'b1,
    parameter bit MANUAL_PRESENT = 1'b1
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic supply_low_in,
    input wire logic manual_reset_n_input_in,
    input wire logic watchdog_toggle_input_in,
    input wire logic reset_od_pin_in,
    output logic reset_n_out,
    output logic reset_out,
    output logic reset_od_out,
    output logic reset_od_oe_out
);

    typedef struct packed {
        logic supply_meta;
        logic supply_sync;
        logic manual_level;
        supervisor_pkg::deb_cnt_t deb_count;
        logic toggle_prev;
        supervisor_pkg::wd_cnt_t wd_count;
        logic wd_expire;
        logic rst_n;
        logic rst_hi;
        logic od_oe;
    } sup_state_t;

    // Every flop is taken to its asserting or cleared value
    localparam sup_state_t ST_ASSERT = '{
        supply_meta: 1'b1,
        supply_sync: 1'b1,
        manual_level: 1'b1,
        deb_count: supervisor_pkg::DEB_CNT_ZERO,
        toggle_prev: 1'b0,
        wd_count: supervisor_pkg::WD_CNT_ZERO,
        wd_expire: 1'b0,
        rst_n: 1'b0,
        rst_hi: 1'b1,
        od_oe: 1'b1
    };

    localparam supervisor_pkg::wd_cnt_t WD_LAST = supervisor_pkg::wd_cnt_t'(WD_CYCLES - 1);
    localparam supervisor_pkg::deb_cnt_t DEB_LAST =
        supervisor_pkg::deb_cnt_t'(DEBOUNCE_CYCLES - 1);

    localparam bit HAS_LOW_PP =
        (OUT_MODE == supervisor_pkg::OUT_PP_LOW) || (OUT_MODE == supervisor_pkg::OUT_PP_BOTH);
    localparam bit HAS_HIGH_PP =
        (OUT_MODE == supervisor_pkg::OUT_PP_HIGH) || (OUT_MODE == supervisor_pkg::OUT_PP_BOTH);
    localparam bit HAS_OD = (OUT_MODE == supervisor_pkg::OUT_OD_LOW);

    sup_state_t st;
    sup_state_t next_st;

    hold_timer_if hold ();

    logic manual_asserted;
    logic toggle_edge;
    logic cause;
    logic reset_now;

    reset_hold_timer #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_hold (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .hold(hold.timer)
    );

    // Debounced manual level; absent input reads as released
    assign manual_asserted = MANUAL_PRESENT && !st.manual_level;

    // Registered previous level catches both edges; inputs are sampled at
    // 10 ns so a 50 ns pulse is seen by at least four edges
    assign toggle_edge = WATCHDOG_PRESENT && (watchdog_toggle_input_in != st.toggle_prev);

    // Only the second synchroniser flop feeds the cause
    assign cause = st.supply_sync || manual_asserted || st.wd_expire;

    // Output flops take reset on the edge after a cause appears, not waiting for the hold timer
    assign reset_now = hold.active || cause;

    always_comb begin
        hold.cause = cause;
        hold.supply_low_raw = supply_low_in;
    end

    always_comb begin
        next_st = st;

        // Two-flop synchroniser for the supply-low level
        next_st.supply_meta = supply_low_in;
        next_st.supply_sync = st.supply_meta;

        // Manual reset filter: a new level is accepted only after it holds
        // for the whole window, so contact bounce yields one reset
        if (!MANUAL_PRESENT) begin
            next_st.manual_level = 1'b1;
            next_st.deb_count = supervisor_pkg::DEB_CNT_ZERO;
        end else if (manual_reset_n_input_in == st.manual_level) begin
            next_st.deb_count = supervisor_pkg::DEB_CNT_ZERO;
        end else if (st.deb_count >= DEB_LAST) begin
            // Window below 1 us, so a guaranteed low pulse is always taken
            next_st.manual_level = manual_reset_n_input_in;
            next_st.deb_count = supervisor_pkg::DEB_CNT_ZERO;
        end else begin
            next_st.deb_count = st.deb_count + supervisor_pkg::DEB_CNT_ONE;
        end

        // Watchdog counter
        next_st.toggle_prev = watchdog_toggle_input_in;
        next_st.wd_expire = 1'b0;
        if (!WATCHDOG_PRESENT) begin
            next_st.wd_count = supervisor_pkg::WD_CNT_ZERO;
        end else if (hold.active || manual_asserted || toggle_edge) begin
            // Held at zero while reset stands, counts from release
            next_st.wd_count = supervisor_pkg::WD_CNT_ZERO;
        end else if (st.wd_count >= WD_LAST) begin
            // Stuck toggle input: one-cycle cause starts a full hold
            next_st.wd_expire = 1'b1;
            next_st.wd_count = supervisor_pkg::WD_CNT_ZERO;
        end else begin
            next_st.wd_count = st.wd_count + supervisor_pkg::WD_CNT_ONE;
        end

        // Output forms; unused forms rest at their released level
        next_st.rst_n = !(HAS_LOW_PP && reset_now);
        next_st.rst_hi = HAS_HIGH_PP && reset_now;
        next_st.od_oe = HAS_OD && reset_now;
    end

    // Supply low forces every output flop at once; the synchronous path
    // still decides release so the hold only starts once the level is stable
    always_ff @(posedge clk_sys_in or posedge supply_low_in) begin
        if (supply_low_in) begin
            st <= ST_ASSERT;
        end else if (rst_in) begin
            st <= ST_ASSERT;
        end else begin
            st <= next_st;
        end
    end

    // An unused form shows released even though the preset drives it
    always_comb begin
        reset_n_out = st.rst_n || !HAS_LOW_PP;
        reset_out = st.rst_hi && HAS_HIGH_PP;
        reset_od_oe_out = st.od_oe && HAS_OD;
        reset_od_out = 1'b0;
    end

    // The wired level of the open-drain pin is not needed by this end
    logic unused_pin;
    assign unused_pin = reset_od_pin_in;

endmodule // supervisor_reset_watchdog

// File: tb/supervisor_chk_sva.sv
// Port checker for the reset supervisor, bound to its top module.
// Assumes the OUT_PP_BOTH build and one clock with synchronous reset.
`timescale 1ns/1ps
module supervisor_chk #(
    parameter int unsigned HOLD_CYCLES = 20,
    parameter int unsigned WD_CYCLES = 100,
    parameter int unsigned DEBOUNCE_CYCLES = 3
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic supply_low_in,
    input wire logic manual_reset_n_input_in,
    input wire logic watchdog_toggle_input_in,
    input wire logic reset_od_pin_in,
    input wire logic reset_n_out,
    input wire logic reset_out,
    input wire logic reset_od_out,
    input wire logic reset_od_oe_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic [31:0] on_cnt, idle_cnt, still_cnt, mlo_cnt, mhi_cnt;
    logic [3:0] sup_h;
    logic wd_q;
    wire asrt = ~reset_n_out;
    // Still count also clears on any manual low, so a refused glitch cannot fake a late expiry
    always_ff @(posedge clk_sys_in) begin
        wd_q <= watchdog_toggle_input_in;
        if (rst_in) begin
            {on_cnt, idle_cnt, still_cnt, mlo_cnt, mhi_cnt} <= '0;
            sup_h <= 4'h0;
        end else begin
            sup_h <= {sup_h[2:0], supply_low_in};
            on_cnt <= asrt ? on_cnt + 1 : 32'h0;
            idle_cnt <= (asrt && !supply_low_in && manual_reset_n_input_in) ? idle_cnt + 1 : 32'h0;
            still_cnt <= (asrt || !manual_reset_n_input_in
                || wd_q != watchdog_toggle_input_in) ? 32'h0 : still_cnt + 1;
            mlo_cnt <= manual_reset_n_input_in ? 32'h0 : mlo_cnt + 1;
            mhi_cnt <= manual_reset_n_input_in ? mhi_cnt + 1 : 32'h0;
        end
    end
    property p_sup; supply_low_in |-> asrt; endproperty
    a_sup: assert property (p_sup) else $error("reset missing with supply low");
    property p_man; mlo_cnt > DEBOUNCE_CYCLES + 1 |-> asrt; endproperty
    a_man: assert property (p_man) else $error("reset missing with manual low");
    property p_pol; reset_out == asrt; endproperty
    a_pol: assert property (p_pol) else $error("reset polarities disagree");
    property p_od; !reset_od_oe_out && !reset_od_out; endproperty
    a_od: assert property (p_od) else $error("open-drain pin driven in push-pull build");
    property p_hold; $fell(asrt) |-> on_cnt >= HOLD_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("reset released too early");
    property p_rel; idle_cnt < HOLD_CYCLES + DEBOUNCE_CYCLES + 4; endproperty
    a_rel: assert property (p_rel) else $error("reset held too long");
    property p_late; still_cnt <= WD_CYCLES + 2; endproperty
    a_late: assert property (p_late) else $error("watchdog expiry missed");
    property p_early; $rose(asrt) && sup_h == 4'h0 && !supply_low_in
        && mhi_cnt > DEBOUNCE_CYCLES + 3 |-> still_cnt + 2 >= WD_CYCLES; endproperty
    a_early: assert property (p_early) else $error("watchdog expired early");
endmodule // supervisor_chk
bind supervisor_reset_watchdog supervisor_chk #(.HOLD_CYCLES(HOLD_CYCLES),
    .WD_CYCLES(WD_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_supervisor_chk (.*);

// File: tb/host_model.sv
// Host processor model: services the watchdog by toggling its input.
// Assumes the bench sets the toggle spacing in clock cycles.
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys_in,
    input wire logic en_in,
    input wire logic [7:0] gap_in,
    output logic toggle_out
);
    logic [7:0] cnt = 8'h00;
    initial toggle_out = 1'b0;
    // Levels last several cycles, far past the shortest detectable pulse
    always @(posedge clk_sys_in) begin
        if (en_in && cnt >= gap_in) begin
            toggle_out <= ~toggle_out; // Serviced well inside the expiry period
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // host_model

// File: tb/tb.sv
// Self-checking bench for the reset supervisor with shortened counts.
// Assumes the host model is the only party toggling the watchdog input.
`timescale 1ns/1ps
module tb;
    localparam int HOLD = 20;
    localparam int WD = 100;
    localparam int DEB = 3;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic supply_low_in = 1'b0;
    logic manual_n = 1'b1;
    logic host_en = 1'b0;
    logic toggle, reset_n_out, reset_out, od, od_oe, seen;
    int n_mismatch = 0;
    int check_count = 0;
    int n;
    always #5 clk_sys_in = ~clk_sys_in;
    supervisor_reset_watchdog #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD), .DEBOUNCE_CYCLES(DEB),
        .OUT_MODE(supervisor_pkg::OUT_PP_BOTH)) u_supervisor_reset_watchdog (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .supply_low_in(supply_low_in),
        .manual_reset_n_input_in(manual_n), .watchdog_toggle_input_in(toggle),
        .reset_od_pin_in(1'b1), .reset_n_out(reset_n_out), .reset_out(reset_out),
        .reset_od_out(od), .reset_od_oe_out(od_oe));
    host_model u_host_model (.clk_sys_in(clk_sys_in), .en_in(host_en), .gap_in(8'h14),
        .toggle_out(toggle));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Counts cycles until the active-low output reaches lvl; a spent bound ends the run
    task automatic wait_out(input logic lvl, input int max);
        n = 0;
        while (reset_n_out !== lvl) begin
            if (n == max) begin
                n_mismatch++;
                end_of_test();
            end
            n++;
            @(posedge clk_sys_in);
            #1;
        end
    endtask
    task automatic hold_chk();
        wait_out(1'b1, HOLD + DEB + 6);
        check(n >= HOLD, 1);
        check(reset_out, 1'b0);
    endtask
    task automatic t_power();
        repeat (16) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        check(reset_n_out, 1'b0);
        hold_chk();
    endtask
    task automatic t_wd_ok();
        seen = 1'b0;
        host_en <= 1'b1;
        repeat (3 * WD) begin
            @(posedge clk_sys_in);
            #1;
            seen = seen | ~reset_n_out;
        end
        check(seen, 1'b0);
    endtask
    task automatic t_supply();
        @(posedge clk_sys_in) supply_low_in <= 1'b1;
        #1;
        check(reset_n_out, 1'b0);
        repeat (5) @(posedge clk_sys_in);
        supply_low_in <= 1'b0;
        hold_chk();
    endtask
    task automatic t_glitch();
        @(posedge clk_sys_in) manual_n <= 1'b0;
        repeat (DEB - 1) @(posedge clk_sys_in);
        manual_n <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        #1;
        check(reset_n_out, 1'b1);
    endtask
    task automatic t_manual();
        @(posedge clk_sys_in) manual_n <= 1'b0;
        // Low held well past the filter window, as a real press would be
        repeat (DEB + 8) @(posedge clk_sys_in);
        #1;
        check(reset_n_out, 1'b0);
        @(posedge clk_sys_in) manual_n <= 1'b1;
        hold_chk();
    endtask
    task automatic t_wd_exp();
        @(posedge clk_sys_in) host_en <= 1'b0;
        wait_out(1'b0, WD + 5);
        check(n + 22 >= WD && n <= WD + 2, 1);
        hold_chk();
        wait_out(1'b0, WD + 5);
        check(n + 2 >= WD && n <= WD + 2, 1);
        check(od | od_oe, 1'b0);
    endtask
    initial begin
        t_power();
        t_wd_ok();
        t_supply();
        t_glitch();
        t_manual();
        t_wd_exp();
        end_of_test();
    end
endmodule // tb
